// ==== rdu_host.sv ====
// terminal model on the far side: frames characters in and decodes the port's output
`timescale 1ns/100ps
`default_nettype none
module rdu_host #(
  parameter int BIT = 13008
) (
  input  wire logic clk,
  input  wire logic txd,
  input  wire logic dtr,
  output var  logic rxd,
  output var  logic dsr
);
  logic [9:0] sh;
  logic [6:0] rx_data;
  logic       rx_par;
  logic [1:0] rx_stop;
  int         rx_cnt = 0;
  initial begin
    rxd = 1'b1;
    dsr = 1'b1;
  end
  task automatic set_ready(input logic v);
    @(posedge clk);
    dsr <= v;
  endtask : set_ready
  // start, lsb-first data, even parity, two stops
  task automatic send(input logic [6:0] ch, input logic bad, input logic urgent);
    logic [10:0] f;
    f = {2'b11, ^ch ^ bad, ch, 1'b0};
    // ordinary traffic waits for dtr, urgent traffic does not
    while (!urgent && dtr !== 1'b1) @(posedge clk);
    @(posedge clk);
    for (int i = 0; i < 11; i++) begin
      rxd <= f[i];
      repeat (BIT) @(posedge clk);
    end
  endtask : send
  // mid-bit sampling of each slot after the start edge
  initial begin
    forever begin
      @(negedge txd);
      repeat (BIT / 2) @(posedge clk);
      if (txd === 1'b0) begin
        for (int i = 0; i < 10; i++) begin
          repeat (BIT) @(posedge clk);
          sh = {txd, sh[9:1]};
        end
        rx_data = sh[6:0];
        rx_par = sh[7];
        rx_stop = sh[9:8];
        rx_cnt++;
      end
    end
  end
endmodule : rdu_host
`default_nettype wire

// ==== rdu_pkg.sv ====
// package of constants and types for the dtr/dsr serial port
package rdu_pkg;
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned OVS    = 16;
  // baud select codes
  localparam logic [2:0] BAUD_300   = 3'h0;
  localparam logic [2:0] BAUD_600   = 3'h1;
  localparam logic [2:0] BAUD_1200  = 3'h2;
  localparam logic [2:0] BAUD_2400  = 3'h3;
  localparam logic [2:0] BAUD_4800  = 3'h4;
  localparam logic [2:0] BAUD_9600  = 3'h5;
  // character formats
  localparam logic [1:0] FMT_NONE8  = 2'h0;
  localparam logic [1:0] FMT_EVEN7  = 2'h1;
  localparam logic [1:0] FMT_ODD7   = 2'h2;
  localparam int unsigned STOP_BITS = 2;
  // register byte offsets
  localparam logic [4:0] OFS_CTRL   = 5'h00;
  localparam logic [4:0] OFS_CMD    = 5'h04;
  localparam logic [4:0] OFS_STAT   = 5'h08;
  localparam logic [4:0] OFS_RXDATA = 5'h0c;
  localparam logic [4:0] OFS_TXDATA = 5'h10;
  localparam logic [4:0] OFS_INT_ST = 5'h14;
  localparam logic [4:0] OFS_INT_CL = 5'h18;
  localparam logic [4:0] OFS_INT_EN = 5'h1c;
  // field positions
  localparam int unsigned CTRL_FMT_LSB = 4;
  localparam int unsigned CMD_HOLD     = 0;
  localparam int unsigned CMD_RXFLUSH  = 1;
  localparam int unsigned RXD_VALID    = 8;
  // event bits
  localparam int unsigned EV_RXCHAR = 0;
  localparam int unsigned EV_NL     = 1;
  localparam int unsigned EV_PERR   = 2;
  localparam int unsigned EV_FERR   = 3;
  localparam int unsigned EV_CTRLC  = 4;
  localparam int unsigned EV_OVFL   = 5;
  localparam int unsigned EV_TXDONE = 6;
  localparam int unsigned EV_W      = 7;
  localparam logic [7:0] CH_CTRLC   = 8'h03;
  localparam logic [7:0] CH_NL      = 8'h0a;
  localparam int unsigned RX_THRESH = 100;
  typedef struct packed {
    logic [1:0] fmt;
    logic [2:0] baud;
  } rdu_cfg_type;
  localparam rdu_cfg_type CFG_RST = '{fmt: FMT_EVEN7, baud: BAUD_9600};
  typedef struct packed {
    logic       read;
    logic       write;
    logic [4:0] address;
    logic [31:0] writedata;
  } rdu_req_type;
  // clock cycles per oversampling tick for a baud code
  function automatic logic [15:0] baud_div(input logic [2:0]  sel,
                                           input int unsigned clk_hz);
    int unsigned b;
    case (sel)
      BAUD_300:  b = 300;
      BAUD_600:  b = 600;
      BAUD_1200: b = 1200;
      BAUD_2400: b = 2400;
      BAUD_4800: b = 4800;
      default:   b = 9600;
    endcase
    return 16'(clk_hz / (b * OVS));
  endfunction : baud_div
endpackage : rdu_pkg

// ==== rdu_properties.sv ====
// concurrent checks on the serial port's register bus and line pins
`timescale 1ns/100ps
`default_nettype none
module rdu_properties #(
  parameter int unsigned CLK_FREQ = rdu_pkg::CLK_HZ
) (
  input wire logic                 clk,
  input wire logic                 rst_n,
  input wire rdu_pkg::rdu_req_type av_req,
  input wire logic [31:0]          av_readdata,
  input wire logic                 av_waitrequest,
  input wire logic                 irq,
  input wire logic                 rxd,
  input wire logic                 txd,
  input wire logic                 dtr,
  input wire logic                 dsr
);
  import rdu_pkg::*;
  // frame timing only holds for the 9600 baud reset setting
  localparam int BIT = int'(OVS * (CLK_FREQ / (9600 * OVS)));
  logic        txd_q_ff;
  logic [17:0] frame_cnt_ff;
  logic [3:0]  dsr_low_ff;
  logic        start_evt;
  assign start_evt = txd_q_ff && !txd && frame_cnt_ff == 18'h0;
  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txd_q_ff <= 1'b1;
    end else begin
      txd_q_ff <= txd;
    end
  end
  // eleven bit slots counted from the start edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_cnt_ff <= 18'h0;
    end else if (frame_cnt_ff != 18'h0) begin
      frame_cnt_ff <= frame_cnt_ff - 18'h1;
    end else if (start_evt) begin
      frame_cnt_ff <= 18'(11 * BIT - 1);
    end
  end
  // saturating run length of a false dsr
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dsr_low_ff <= 4'h0;
    end else if (dsr) begin
      dsr_low_ff <= 4'h0;
    end else if (dsr_low_ff != 4'hf) begin
      dsr_low_ff <= dsr_low_ff + 4'h1;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_wait_after_req: assert property ((av_req.read || av_req.write) && av_waitrequest
    |=> !av_waitrequest) else $error("request not answered after one wait cycle");
  a_wait_single_low: assert property (!av_waitrequest |=> av_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_rdata_idle_zero: assert property (av_waitrequest |-> av_readdata == 32'h0)
    else $error("read data not zero outside an answer");
  a_txd_reset_idle: assert property ($rose(rst_n) |-> txd)
    else $error("serial output not at mark after reset");
  a_dtr_after_reset: assert property ($rose(rst_n) |=> dtr)
    else $error("dtr not true after reset release");
  a_start_bit_low: assert property (frame_cnt_ff > 18'(10 * BIT) |-> !txd)
    else $error("start bit not held low for one bit time");
  a_stop_bits_high: assert property (frame_cnt_ff != 18'h0 && frame_cnt_ff <= 18'(2 * BIT)
    |-> txd) else $error("stop bits not at mark");
  a_bit_slot_held: assert property (frame_cnt_ff > 18'h1 && frame_cnt_ff % BIT != 1
    |=> $stable(txd)) else $error("line changed inside a bit slot");
  a_start_needs_dsr: assert property (start_evt |-> dsr_low_ff < 4'h6)
    else $error("character started while dsr false");
  c_frame_start: cover property (start_evt);
  c_read_answer: cover property (!av_waitrequest && av_req.read);
  c_irq_high: cover property (irq);
  c_both_false: cover property (!dtr && !dsr);
endmodule : rdu_properties
`default_nettype wire

// ==== rdu_uart.sv ====
// dtr/dsr handshaked serial port with avalon-mm register slave
//
// Register access over Avalon-MM and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module rdu_uart #(
  parameter int unsigned CLK_FREQ = rdu_pkg::CLK_HZ,
  parameter int unsigned RX_DEPTH = 128,
  parameter int unsigned TX_DEPTH = 16
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire rdu_pkg::rdu_req_type av_req,
  output var  logic [31:0]          av_readdata,
  output var  logic                 av_waitrequest,
  output var  logic                 irq,
  input  wire logic                 rxd,
  output var  logic                 txd,
  output var  logic                 dtr,
  input  wire logic                 dsr
);
  import rdu_pkg::*;

  localparam int unsigned RAW = $clog2(RX_DEPTH);
  localparam int unsigned TAW = $clog2(TX_DEPTH);

  typedef enum logic [4:0] {
    S_IDLE  = 5'h01,
    S_START = 5'h02,
    S_DATA  = 5'h04,
    S_PAR   = 5'h08,
    S_STOP  = 5'h10
  } rdu_st_type;

  //////////////////////////////////////////////////////////////////////////////
  // bus slave
  logic            wait_ff;
  logic [31:0]     rdata_ff;
  rdu_cfg_type     cfg_ff;
  logic [EV_W-1:0] int_st_ff;
  logic [EV_W-1:0] int_en_ff;
  logic            irq_ff;
  logic            hold_ff;
  logic            acc;
  logic            wr_acc;
  logic            rd_acc;
  logic [EV_W-1:0] ev;
  logic [EV_W-1:0] clr;
  logic [31:0]     nxt_rdata;
  logic [RAW:0]    rx_cnt_ff;
  logic [TAW:0]    tx_cnt_ff;
  logic [7:0]      rx_mem [RX_DEPTH];
  logic [RAW-1:0]  rx_rd_ff;
  logic [RAW-1:0]  rx_wr_ff;
  logic [7:0]      tx_mem [TX_DEPTH];
  logic [TAW-1:0]  tx_rd_ff;
  logic [TAW-1:0]  tx_wr_ff;
  rdu_st_type      tx_st_ff;
  logic            dsr_s1_ff;
  logic            dsr_s2_ff;
  logic            suspended;

  // one wait cycle, then a single cycle with waitrequest low
  assign acc    = (av_req.read | av_req.write) & ~wait_ff;
  assign wr_acc = acc & av_req.write;
  assign rd_acc = acc & av_req.read;

  always_comb begin
    nxt_rdata = 32'h0;
    if (av_req.address == OFS_CTRL) begin
      nxt_rdata[CTRL_FMT_LSB+:2] = cfg_ff.fmt;
      nxt_rdata[2:0]             = cfg_ff.baud;
    end else if (av_req.address == OFS_STAT) begin
      nxt_rdata[0]     = dtr;
      nxt_rdata[1]     = dsr_s2_ff;
      nxt_rdata[2]     = suspended;
      nxt_rdata[3]     = hold_ff;
      nxt_rdata[4]     = (tx_st_ff != S_IDLE);
      nxt_rdata[15:8]  = 8'(rx_cnt_ff);
      nxt_rdata[23:16] = 8'(tx_cnt_ff);
    end else if (av_req.address == OFS_RXDATA) begin
      nxt_rdata[7:0]       = rx_mem[rx_rd_ff];
      nxt_rdata[RXD_VALID] = (rx_cnt_ff != '0);
    end else if (av_req.address == OFS_INT_ST) begin
      nxt_rdata[EV_W-1:0] = int_st_ff;
    end else if (av_req.address == OFS_INT_EN) begin
      nxt_rdata[EV_W-1:0] = int_en_ff;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_ff  <= 1'b1;
      rdata_ff <= 32'h0;
    end else begin
      wait_ff  <= ~((av_req.read | av_req.write) & wait_ff);
      rdata_ff <= ((av_req.read & wait_ff) ? nxt_rdata : 32'h0);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ff    <= CFG_RST;
      int_en_ff <= '0;
    end else if (wr_acc && av_req.address == OFS_CTRL) begin
      cfg_ff.baud <= (av_req.writedata[2:0] > BAUD_9600) ? BAUD_9600
                                                         : av_req.writedata[2:0];
      cfg_ff.fmt  <= (av_req.writedata[CTRL_FMT_LSB+:2] > FMT_ODD7) ? FMT_EVEN7
                                                        : av_req.writedata[CTRL_FMT_LSB+:2];
    end else if (wr_acc && av_req.address == OFS_INT_EN) begin
      int_en_ff <= av_req.writedata[EV_W-1:0];
    end
  end

  // sticky events: a set in the clearing cycle survives
  assign clr = (wr_acc && av_req.address == OFS_INT_CL) ? av_req.writedata[EV_W-1:0] : '0;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_st_ff <= '0;
      irq_ff    <= 1'b0;
    end else begin
      int_st_ff <= (int_st_ff & ~clr) | ev;
      irq_ff    <= |(((int_st_ff & ~clr) | ev) & int_en_ff);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // bit timing
  logic [15:0] div_cnt_ff;
  logic        tick;
  logic        par_on;
  logic [2:0]  last_bit;

  assign tick     = (div_cnt_ff == baud_div(cfg_ff.baud, CLK_FREQ) - 16'h1);
  assign par_on   = (cfg_ff.fmt != FMT_NONE8);
  assign last_bit = par_on ? 3'h6 : 3'h7;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_ff <= 16'h0;
    end else begin
      div_cnt_ff <= tick ? 16'h0 : div_cnt_ff + 16'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // receiver
  logic       rx_s1_ff;
  logic       rx_s2_ff;
  rdu_st_type rx_st_ff;
  logic [3:0] rx_ph_ff;
  logic [2:0] rx_bit_ff;
  logic       rx_stop_ff;
  logic [7:0] rx_sh_ff;
  logic       rx_perr_ff;
  logic       rx_ferr_ff;
  logic       rx_done_ff;
  logic [7:0] rx_byte_ff;
  logic       rx_pe_ff;
  logic       rx_fe_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_s1_ff  <= 1'b1;
      rx_s2_ff  <= 1'b1;
      dsr_s1_ff <= 1'b0;
      dsr_s2_ff <= 1'b0;
    end else begin
      rx_s1_ff  <= rxd;
      rx_s2_ff  <= rx_s1_ff;
      dsr_s1_ff <= dsr;
      dsr_s2_ff <= dsr_s1_ff;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_st_ff   <= S_IDLE;
      rx_ph_ff   <= 4'h0;
      rx_bit_ff  <= 3'h0;
      rx_stop_ff <= 1'b0;
      rx_sh_ff   <= 8'h0;
      rx_perr_ff <= 1'b0;
      rx_ferr_ff <= 1'b0;
      rx_done_ff <= 1'b0;
      rx_byte_ff <= 8'h0;
      rx_pe_ff   <= 1'b0;
      rx_fe_ff   <= 1'b0;
    end else begin
      rx_done_ff <= 1'b0;
      case (rx_st_ff)
        S_IDLE: begin
          rx_ph_ff <= 4'h0;
          if (!rx_s2_ff) begin
            rx_st_ff <= S_START;
          end
        end
        // one start bit, checked at its middle
        S_START: if (tick) begin
          rx_ph_ff <= rx_ph_ff + 4'h1;
          if (rx_ph_ff == 4'h7) begin
            rx_ph_ff   <= 4'h0;
            rx_bit_ff  <= 3'h0;
            rx_stop_ff <= 1'b0;
            rx_perr_ff <= 1'b0;
            rx_ferr_ff <= 1'b0;
            rx_st_ff   <= rx_s2_ff ? S_IDLE : S_DATA;
          end
        end
        S_DATA: if (tick) begin
          rx_ph_ff <= rx_ph_ff + 4'h1;
          if (rx_ph_ff == 4'hf) begin
            rx_sh_ff  <= {rx_s2_ff, rx_sh_ff[7:1]};
            rx_bit_ff <= rx_bit_ff + 3'h1;
            if (rx_bit_ff == last_bit) begin
              rx_st_ff <= par_on ? S_PAR : S_STOP;
            end
          end
        end
        S_PAR: if (tick) begin
          rx_ph_ff <= rx_ph_ff + 4'h1;
          if (rx_ph_ff == 4'hf) begin
            rx_perr_ff <= (^rx_sh_ff[7:1] ^ rx_s2_ff) != (cfg_ff.fmt == FMT_ODD7);
            rx_st_ff   <= S_STOP;
          end
        end
        // both stop bits must be mark
        S_STOP: if (tick) begin
          rx_ph_ff <= rx_ph_ff + 4'h1;
          if (rx_ph_ff == 4'hf) begin
            rx_stop_ff <= 1'b1;
            if (!rx_s2_ff) begin
              rx_ferr_ff <= 1'b1;
            end
            if (rx_stop_ff) begin
              rx_done_ff <= 1'b1;
              rx_byte_ff <= par_on ? {1'b0, rx_sh_ff[7:1]} : rx_sh_ff;
              rx_pe_ff   <= rx_perr_ff;
              rx_fe_ff   <= rx_ferr_ff | ~rx_s2_ff;
              rx_st_ff   <= S_IDLE;
            end
          end
        end
        default: rx_st_ff <= S_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // receive buffer and hold-off
  logic ctrlc;
  logic rx_push;
  logic rx_pop;
  logic rx_flush;
  logic tx_done;

  assign ctrlc    = rx_done_ff & (rx_byte_ff == CH_CTRLC);
  // characters other than ctrl-c stored while the buffer is not full
  assign rx_push  = rx_done_ff & ~ctrlc & (rx_cnt_ff != (RAW+1)'(RX_DEPTH));
  assign rx_pop   = rd_acc & (av_req.address == OFS_RXDATA) & (rx_cnt_ff != '0);
  assign rx_flush = wr_acc & (av_req.address == OFS_CMD) & av_req.writedata[CMD_RXFLUSH];

  always_ff @(posedge clk) begin
    if (rx_push) begin
      rx_mem[rx_wr_ff] <= rx_byte_ff;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_rd_ff  <= '0;
      rx_wr_ff  <= '0;
      rx_cnt_ff <= '0;
    end else if (rx_flush) begin
      rx_rd_ff  <= '0;
      rx_wr_ff  <= '0;
      rx_cnt_ff <= '0;
    end else begin
      rx_wr_ff  <= rx_wr_ff + RAW'(rx_push);
      rx_rd_ff  <= rx_rd_ff + RAW'(rx_pop);
      rx_cnt_ff <= rx_cnt_ff + (RAW+1)'(rx_push) - (RAW+1)'(rx_pop);
    end
  end

  assign ev[EV_RXCHAR] = rx_push;
  assign ev[EV_NL]     = rx_push & (rx_byte_ff == CH_NL);
  assign ev[EV_PERR]   = rx_done_ff & rx_pe_ff;
  assign ev[EV_FERR]   = rx_done_ff & rx_fe_ff;
  assign ev[EV_CTRLC]  = ctrlc;
  assign ev[EV_OVFL]   = rx_done_ff & ~ctrlc & ~rx_push;
  assign ev[EV_TXDONE] = tx_done;

  // response hold, ended by the drained queue or ctrl-c
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_ff <= 1'b0;
    end else if (tx_done || ctrlc) begin
      hold_ff <= 1'b0;
    end else if (wr_acc && av_req.address == OFS_CMD && av_req.writedata[CMD_HOLD]) begin
      hold_ff <= 1'b1;
    end
  end

  logic dtr_ff;
  // dtr false at RX_THRESH buffered characters, a response or a dsr stall
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dtr_ff <= 1'b0;
    end else begin
      dtr_ff <= ~((rx_cnt_ff >= (RAW+1)'(RX_THRESH)) | hold_ff | suspended);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // transmit queue and transmitter
  logic       tx_push;
  logic       tx_pop;
  logic       txd_ff;
  logic [3:0] tx_ph_ff;
  logic [2:0] tx_bit_ff;
  logic       tx_stop_ff;
  logic [7:0] tx_sh_ff;
  logic       tx_par_ff;

  assign tx_push   = wr_acc & (av_req.address == OFS_TXDATA) &
                     (tx_cnt_ff != (TAW+1)'(TX_DEPTH));
  // dsr looked at before each character
  assign tx_pop    = (tx_st_ff == S_IDLE) & tick & (tx_cnt_ff != '0) & dsr_s2_ff & ~ctrlc;
  assign suspended = (tx_st_ff == S_IDLE) & (tx_cnt_ff != '0) & ~dsr_s2_ff;
  assign tx_done   = (tx_st_ff == S_STOP) & tick & (tx_ph_ff == 4'hf) & tx_stop_ff &
                     (tx_cnt_ff == '0);

  always_ff @(posedge clk) begin
    if (tx_push) begin
      tx_mem[tx_wr_ff] <= av_req.writedata[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_rd_ff  <= '0;
      tx_wr_ff  <= '0;
      tx_cnt_ff <= '0;
    end else if (ctrlc) begin
      tx_rd_ff  <= '0;
      tx_wr_ff  <= '0;
      tx_cnt_ff <= '0;
    end else begin
      tx_wr_ff  <= tx_wr_ff + TAW'(tx_push);
      tx_rd_ff  <= tx_rd_ff + TAW'(tx_pop);
      tx_cnt_ff <= tx_cnt_ff + (TAW+1)'(tx_push) - (TAW+1)'(tx_pop);
    end
  end

  // start, data, optional parity, two stops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_st_ff   <= S_IDLE;
      txd_ff     <= 1'b1;
      tx_ph_ff   <= 4'h0;
      tx_bit_ff  <= 3'h0;
      tx_stop_ff <= 1'b0;
      tx_sh_ff   <= 8'h0;
      tx_par_ff  <= 1'b0;
    end else begin
      case (tx_st_ff)
        S_IDLE: begin
          txd_ff   <= 1'b1;
          tx_ph_ff <= 4'h0;
          if (tx_pop) begin
            tx_sh_ff   <= tx_mem[tx_rd_ff];
            tx_par_ff  <= ^tx_mem[tx_rd_ff][6:0] ^ (cfg_ff.fmt == FMT_ODD7);
            tx_bit_ff  <= 3'h0;
            tx_stop_ff <= 1'b0;
            txd_ff     <= 1'b0;
            tx_st_ff   <= S_START;
          end
        end
        S_START: if (tick) begin
          tx_ph_ff <= tx_ph_ff + 4'h1;
          if (tx_ph_ff == 4'hf) begin
            txd_ff   <= tx_sh_ff[0];
            tx_st_ff <= S_DATA;
          end
        end
        S_DATA: if (tick) begin
          tx_ph_ff <= tx_ph_ff + 4'h1;
          if (tx_ph_ff == 4'hf) begin
            tx_sh_ff  <= {1'b0, tx_sh_ff[7:1]};
            tx_bit_ff <= tx_bit_ff + 3'h1;
            txd_ff    <= tx_sh_ff[1];
            if (tx_bit_ff == last_bit) begin
              txd_ff   <= par_on ? tx_par_ff : 1'b1;
              tx_st_ff <= par_on ? S_PAR : S_STOP;
            end
          end
        end
        S_PAR: if (tick) begin
          tx_ph_ff <= tx_ph_ff + 4'h1;
          if (tx_ph_ff == 4'hf) begin
            txd_ff   <= 1'b1;
            tx_st_ff <= S_STOP;
          end
        end
        S_STOP: if (tick) begin
          tx_ph_ff <= tx_ph_ff + 4'h1;
          if (tx_ph_ff == 4'hf) begin
            tx_stop_ff <= 1'b1;
            if (tx_stop_ff) begin
              tx_st_ff <= S_IDLE;
            end
          end
        end
        default: tx_st_ff <= S_IDLE;
      endcase
    end
  end

  assign av_readdata    = rdata_ff;
  assign av_waitrequest = wait_ff;
  assign irq            = irq_ff;
  assign txd            = txd_ff;
  assign dtr            = dtr_ff;
endmodule : rdu_uart
`default_nettype wire

// ==== rs232_dtr_dsr_uart_test.sv ====
// self-checking bench for the dtr/dsr serial port
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin failures++; \
  $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end
module rs232_dtr_dsr_uart_test;
  import rdu_pkg::*;
  // slow clock figure keeps a 9600 baud frame short in simulation
  localparam int unsigned BENCH_HZ = 1_536_000;
  localparam int BIT = int'(OVS * (BENCH_HZ / (9600 * OVS)));
  logic        clk;
  logic        rst_n;
  rdu_req_type av_req;
  logic [31:0] av_readdata;
  logic [31:0] q;
  logic        av_waitrequest;
  logic        irq;
  logic        rxd;
  logic        txd;
  logic        dtr;
  logic        dsr;
  int          failures = 0;
  int          check_count = 0;
  rdu_uart #(.CLK_FREQ(BENCH_HZ)) uut (.clk(clk), .rst_n(rst_n), .av_req(av_req),
    .av_readdata(av_readdata), .av_waitrequest(av_waitrequest), .irq(irq), .rxd(rxd),
    .txd(txd), .dtr(dtr), .dsr(dsr));
  rdu_host #(.BIT(BIT)) host (.clk(clk), .txd(txd), .dtr(dtr), .rxd(rxd), .dsr(dsr));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    av_req <= '{read: !wr, write: wr, address: a, writedata: d};
    // no local limit: a hang is ended by the watchdog
    do begin
      @(posedge clk);
    end while (av_waitrequest !== 1'b0);
    q = av_readdata;
    av_req <= '0;
  endtask : bus
  task automatic wait_rx(input int n);
    for (int i = 0; i < 12 * BIT && host.rx_cnt < n; i++) @(posedge clk);
  endtask : wait_rx
  task automatic rd(input logic [4:0] a);
    bus(1'b0, a, 32'h0);
  endtask : rd
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  initial begin
    repeat (40_000) @(posedge clk);
    failures++;
    conclude();
  end
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    av_req = '0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rd(OFS_CTRL);
    `CHK("ctrl reset", 32'h15, q)
    `CHK("dtr ready", 1'b1, dtr)
    rd(5'h1e);
    `CHK("unmapped", 32'h0, q)
    wr(OFS_INT_EN, 32'h7f);
    rd(OFS_INT_EN);
    `CHK("int enable", 32'h7f, q)
    $display("test registers done");
    wr(OFS_CMD, 32'h1);
    repeat (3) @(posedge clk);
    `CHK("dtr hold", 1'b0, dtr)
    wr(OFS_TXDATA, 32'h4b);
    wait_rx(1);
    `CHK("tx data", 7'h4b, host.rx_data)
    `CHK("tx parity", ^7'h4b, host.rx_par)
    `CHK("tx stops", 2'b11, host.rx_stop)
    repeat (BIT) @(posedge clk);
    `CHK("irq drained", 1'b1, irq)
    `CHK("dtr released", 1'b1, dtr)
    rd(OFS_INT_ST);
    `CHK("drained event", 1'b1, q[EV_TXDONE])
    wr(OFS_INT_CL, 32'h7f);
    rd(OFS_INT_ST);
    `CHK("cleared", 32'h0, q)
    `CHK("irq cleared", 1'b0, irq)
    $display("test hold and transmit done");
    wr(OFS_CTRL, 32'h25);
    wr(OFS_TXDATA, 32'h4b);
    wait_rx(2);
    `CHK("odd parity", 1'b1, host.rx_par)
    wr(OFS_CTRL, 32'h05);
    wr(OFS_TXDATA, 32'hc5);
    wait_rx(3);
    `CHK("eight bits", 8'hc5, {host.rx_par, host.rx_data})
    `CHK("eight bit stops", 2'b11, host.rx_stop)
    wr(OFS_CTRL, 32'h37);
    rd(OFS_CTRL);
    `CHK("ctrl clamp", 32'h15, q)
    $display("test formats done");
    host.send(7'h55, 1'b0, 1'b0);
    repeat (10) @(posedge clk);
    rd(OFS_RXDATA);
    `CHK("rx data", 32'h155, q)
    rd(OFS_INT_ST);
    `CHK("rx event", 1'b1, q[EV_RXCHAR])
    host.send(7'h2a, 1'b1, 1'b0);
    repeat (10) @(posedge clk);
    rd(OFS_INT_ST);
    `CHK("parity event", 1'b1, q[EV_PERR])
    wr(OFS_INT_CL, 32'h7f);
    wr(OFS_CMD, 32'h1);
    host.send(CH_NL[6:0], 1'b0, 1'b1); // far side ignores dtr
    repeat (10) @(posedge clk);
    rd(OFS_INT_ST);
    `CHK("newline event", 1'b1, q[EV_NL])
    wr(OFS_CMD, 32'h2);
    rd(OFS_RXDATA);
    `CHK("rx flushed", 1'b0, q[RXD_VALID])
    $display("test receive done");
    host.set_ready(1'b0);
    wr(OFS_TXDATA, 32'h31);
    wr(OFS_TXDATA, 32'h32);
    repeat (2000) @(posedge clk);
    `CHK("txd held", 1'b1, txd)
    `CHK("dtr suspended", 1'b0, dtr)
    rd(OFS_STAT);
    `CHK("suspended", 1'b1, q[2])
    `CHK("tx queued", 8'h2, q[23:16])
    // dsr is already false when ctrl-c goes out
    host.send(CH_CTRLC[6:0], 1'b0, 1'b1);
    repeat (10) @(posedge clk);
    rd(OFS_INT_ST);
    `CHK("ctrl-c event", 1'b1, q[EV_CTRLC])
    rd(OFS_STAT);
    `CHK("tx flushed", 8'h0, q[23:16])
    host.set_ready(1'b1);
    repeat (2 * BIT) @(posedge clk);
    `CHK("nothing sent", 3, host.rx_cnt)
    `CHK("dtr resumed", 1'b1, dtr)
    $display("test suspend and abort done");
    conclude();
  end
endmodule : rs232_dtr_dsr_uart_test
bind rdu_uart rdu_properties #(.CLK_FREQ(CLK_FREQ)) chk (.clk(clk), .rst_n(rst_n), .av_req(av_req),
  .av_readdata(av_readdata), .av_waitrequest(av_waitrequest), .irq(irq), .rxd(rxd),
  .txd(txd), .dtr(dtr), .dsr(dsr));
`default_nettype wire
